//--- pwm_timer_pkg.sv
// Package: register map, field positions and reset values of the PWM timer
// Assumes: used by qualified name only, nothing imports it
package pwm_timer_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 4;
    localparam int PRESC_W = 7;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
    localparam logic [3:0] OFS_COUNTER = 4'h1;
    localparam logic [3:0] OFS_RELOAD = 4'h2;
    localparam logic [3:0] OFS_PWM_CTRL = 4'h3;
    localparam logic [3:0] OFS_DUTY0 = 4'h4;
    localparam logic [3:0] OFS_DUTY3 = 4'h7;
    // ------------------------------------------------------------
    // Control/status fields
    // ------------------------------------------------------------
    localparam int BIT_EXT_CLK = 7;
    localparam int BIT_TAP_HI = 6;
    localparam int BIT_TAP_LO = 4;
    localparam int BIT_RUN = 3;
    localparam int BIT_FORCE = 2;
    localparam int BIT_OIE = 1;
    localparam int BIT_OVF = 0;
    localparam int BIT_OE_LO = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hff;
    localparam logic [6:0] PRESC_RESET = 7'h00;
endpackage

//--- pwm_timer_if.sv
// Interface: counter tick and state shared between the timer core and the channels
// Assumes: all signals live in the sys_clk domain
`timescale 1ns/100ps
`default_nettype none
interface pwm_timer_if;
    logic [7:0] count;
    logic overflow;
    logic [3:0] out_enable;
    logic [3:0] polarity;
    logic [31:0] duty;
    logic [3:0] level;
    modport timer (output count, output overflow, output out_enable, output polarity, output duty, input level);
    modport chan (input count, input overflow, input out_enable, input polarity, input duty, output level);
endinterface
`default_nettype wire

//--- clk_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse for the external clock pin
// Assumes: ext input is asynchronous to sys_clk and slower than sys_clk / 2
`timescale 1ns/100ps
`default_nettype none
module clk_edge_sync (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic async_in,
    output logic rise_pulse
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // One pulse per external rising edge
    assign rise_pulse = sync_ff & ~prev_ff;
endmodule
`default_nettype wire

//--- pwm_channels.sv
// Four PWM channels: compare shadows and output levels
// Assumes: overflow is a one-cycle pulse coinciding with the counter reload
`timescale 1ns/100ps
`default_nettype none
module pwm_channels #(
    parameter int NUM_CH = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    pwm_timer_if.chan tif
);
    logic [7:0] compare_ff [NUM_CH];
    logic [NUM_CH-1:0] raw;

    // ------------------------------------------------------------
    // Compare shadow, reloaded only at overflow to avoid glitches
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (srst) begin
                compare_ff[i] <= pwm_timer_pkg::REG_RESET;
            end else if (tif.overflow) begin
                compare_ff[i] <= tif.duty[8*i +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // Raw level: high while the count is at or below compare
    // ------------------------------------------------------------
    // Compared live: the drop lands on the first count above compare,
    // and a compare below reload never leaves a one-cycle spike
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            raw[i] = tif.count <= compare_ff[i];
        end
    end

    // Polarity applied last so a change shows at once
    assign tif.level = raw ^ tif.polarity;
endmodule
`default_nettype wire

//--- autoreload_timer_pwm.sv
// Top: 8-bit auto-reload timer with prescaler and four PWM outputs
// Assumes: single sys_clk domain; halt_req high while the chip is halted
// Behaviour
// - Each channel compares counter to a shadow reloaded from its duty register at overflow.
// - Per-channel enable bit drives the pin push-pull with PWM; clear leaves it undriven.
// - All channels share frequency counter clock over 256 minus reload value.
// - On overflow every enabled output whose compare is at or above reload goes to its polarity-selected level.
// - On the first count above compare the output returns to its opposite level.
// - Polarity clear: high at or below compare, low above; set inverts.
// - Changing a polarity bit inverts the output immediately.
// - External clock select picks CPU clock at 0, external clock at 1.
// - Three-bit tap field divides input clock by two to the field value.
// - Run enable clear freezes prescaler and counter; set lets them count.
// - Force reload reads zero; writing one loads reload value and clears prescaler.
// - Interrupt request is high only while overflow flag and its enable are set.
// - Overflow flag set at FFh wrap; cleared by reading control/status.
// - Counter register reads live count and loads the counter when written.
// - Overflow reloads the counter and switches PWM levels in the same cycle.
// - PWM generation stops while the chip is halted with the CPU clock selected; the external clock keeps counting.
// - Duty register sets second edge; first edge is the common overflow point.
// - All timer and PWM registers reset to 00h.
// - Counter increments once per prescaled clock rising edge.
// - Writing the counter register also clears the prescaler.
// - After reset counter and prescaler are clear, input is CPU clock.
`timescale 1ns/100ps
`default_nettype none
module autoreload_timer_pwm #(
    parameter int NUM_CH = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_clk_in,
    input wire logic halt_req,
    output logic [3:0] pwm_output_pin_o,
    output logic [3:0] pwm_output_pin_oe,
    output logic overflow_irq
);
    pwm_timer_if tif ();

    logic ext_rise;
    logic halt_meta_ff;
    logic halt_ff;
    logic external_clock_select_ff;
    logic [2:0] prescaler_tap_select_ff;
    logic timer_run_enable_ff;
    logic overflow_irq_enable_ff;
    logic overflow_flag_ff;
    logic [7:0] counter_ff;
    logic [7:0] nxt_counter;
    logic [7:0] reload_ff;
    logic [3:0] out_enable_ff;
    logic [3:0] polarity_ff;
    logic [7:0] duty_ff [NUM_CH];
    logic [6:0] presc_ff;
    logic [6:0] nxt_presc;
    logic input_tick;
    logic count_tick;
    logic overflow;
    logic wr_ctrl;
    logic wr_count;
    logic force_reload;
    logic rd_ctrl;
    logic [7:0] nxt_rdata;

    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction

    // ------------------------------------------------------------
    // Input clock selection and halt synchroniser
    // ------------------------------------------------------------
    clk_edge_sync u_ext_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in(ext_clk_in),
        .rise_pulse(ext_rise)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            halt_meta_ff <= 1'b0;
            halt_ff <= 1'b0;
        end else begin
            halt_meta_ff <= halt_req;
            halt_ff <= halt_meta_ff;
        end
    end

    // CPU clock ticks every cycle; halt stops the CPU-clocked path only
    assign input_tick = external_clock_select_ff ? ext_rise : ~halt_ff;

    // ------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr && addr_is(reg_addr, pwm_timer_pkg::OFS_CTRL_STATUS);
    assign wr_count = reg_wr && addr_is(reg_addr, pwm_timer_pkg::OFS_COUNTER);
    assign force_reload = wr_ctrl && reg_wdata[pwm_timer_pkg::BIT_FORCE];
    assign rd_ctrl = reg_rd && addr_is(reg_addr, pwm_timer_pkg::OFS_CTRL_STATUS);

    // ------------------------------------------------------------
    // Prescaler: a tap fires when all lower bits are one
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] mask;
        mask = 7'((8'h01 << prescaler_tap_select_ff) - 8'h01);
        count_tick = timer_run_enable_ff && input_tick && ((presc_ff & mask) == mask);
        nxt_presc = presc_ff;
        if (force_reload || wr_count) begin
            nxt_presc = pwm_timer_pkg::PRESC_RESET;
        end else if (timer_run_enable_ff && input_tick) begin
            nxt_presc = presc_ff + 7'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            presc_ff <= pwm_timer_pkg::PRESC_RESET;
        end else begin
            presc_ff <= nxt_presc;
        end
    end

    // ------------------------------------------------------------
    // Counter with auto-reload
    // ------------------------------------------------------------
    assign overflow = count_tick && (counter_ff == pwm_timer_pkg::COUNT_TOP) && !wr_count && !force_reload;

    always_comb begin
        nxt_counter = counter_ff;
        if (wr_count) begin
            nxt_counter = reg_wdata;
        end else if (force_reload) begin
            nxt_counter = reload_ff;
        end else if (overflow) begin
            nxt_counter = reload_ff;
        end else if (count_tick) begin
            nxt_counter = counter_ff + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            counter_ff <= pwm_timer_pkg::REG_RESET;
        end else begin
            counter_ff <= nxt_counter;
        end
    end

    // ------------------------------------------------------------
    // Control/status register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            external_clock_select_ff <= 1'b0;
            prescaler_tap_select_ff <= 3'h0;
            timer_run_enable_ff <= 1'b0;
            overflow_irq_enable_ff <= 1'b0;
        end else if (wr_ctrl) begin
            external_clock_select_ff <= reg_wdata[pwm_timer_pkg::BIT_EXT_CLK];
            prescaler_tap_select_ff <= reg_wdata[pwm_timer_pkg::BIT_TAP_HI:pwm_timer_pkg::BIT_TAP_LO];
            timer_run_enable_ff <= reg_wdata[pwm_timer_pkg::BIT_RUN];
            overflow_irq_enable_ff <= reg_wdata[pwm_timer_pkg::BIT_OIE];
        end
    end

    // Set wins over the read-clear so a coincident overflow is kept
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            overflow_flag_ff <= 1'b0;
        end else if (overflow) begin
            overflow_flag_ff <= 1'b1;
        end else if (rd_ctrl) begin
            overflow_flag_ff <= 1'b0;
        end
    end

    assign overflow_irq = overflow_flag_ff && overflow_irq_enable_ff;

    // ------------------------------------------------------------
    // Reload, PWM control and duty registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reload_ff <= pwm_timer_pkg::REG_RESET;
            out_enable_ff <= 4'h0;
            polarity_ff <= 4'h0;
        end else if (reg_wr) begin
            if (addr_is(reg_addr, pwm_timer_pkg::OFS_RELOAD)) begin
                reload_ff <= reg_wdata;
            end else if (addr_is(reg_addr, pwm_timer_pkg::OFS_PWM_CTRL)) begin
                out_enable_ff <= reg_wdata[7:pwm_timer_pkg::BIT_OE_LO];
                polarity_ff <= reg_wdata[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (srst) begin
                duty_ff[i] <= pwm_timer_pkg::REG_RESET;
            end else if (reg_wr && reg_addr == pwm_timer_pkg::OFS_DUTY0 + 4'(i)) begin
                duty_ff[i] <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port, data valid the cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdata = 8'h00;
        if (addr_is(reg_addr, pwm_timer_pkg::OFS_CTRL_STATUS)) begin
            // Force-reload bit always reads zero
            nxt_rdata = {external_clock_select_ff, prescaler_tap_select_ff, timer_run_enable_ff,
                         1'b0, overflow_irq_enable_ff, overflow_flag_ff};
        end else if (addr_is(reg_addr, pwm_timer_pkg::OFS_COUNTER)) begin
            nxt_rdata = counter_ff;
        end else if (addr_is(reg_addr, pwm_timer_pkg::OFS_RELOAD)) begin
            nxt_rdata = reload_ff;
        end else if (addr_is(reg_addr, pwm_timer_pkg::OFS_PWM_CTRL)) begin
            nxt_rdata = {out_enable_ff, polarity_ff};
        end else if (reg_addr >= pwm_timer_pkg::OFS_DUTY0 && reg_addr <= pwm_timer_pkg::OFS_DUTY3) begin
            nxt_rdata = duty_ff[2'(reg_addr - pwm_timer_pkg::OFS_DUTY0)];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Channels and pins
    // ------------------------------------------------------------
    assign tif.count = counter_ff;
    assign tif.overflow = overflow;
    assign tif.out_enable = out_enable_ff;
    assign tif.polarity = polarity_ff;
    assign tif.duty = {duty_ff[3], duty_ff[2], duty_ff[1], duty_ff[0]};

    pwm_channels #(
        .NUM_CH(NUM_CH)
    ) u_channels (
        .sys_clk(sys_clk),
        .srst(srst),
        .tif(tif.chan)
    );

    // Disabled channel leaves the pin to its port logic
    assign pwm_output_pin_o = tif.level & out_enable_ff;
    assign pwm_output_pin_oe = out_enable_ff;
endmodule
`default_nettype wire

//--- autoreload_timer_pwm_props.sv
// Checker: port-level properties of the PWM timer top
// Assumes: bound into autoreload_timer_pwm, one sys_clk domain
`timescale 1ns/100ps
`default_nettype none
module autoreload_timer_pwm_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic ext_clk_in,
    input wire logic halt_req,
    input wire logic [3:0] pwm_output_pin_o,
    input wire logic [3:0] pwm_output_pin_oe,
    input wire logic overflow_irq
);
    logic oie_ff;
    logic ctl_wr;
    logic pwc_wr;
    assign ctl_wr = reg_wr && reg_addr == 4'h0;
    assign pwc_wr = reg_wr && reg_addr == 4'h3;
    // Irq enable mirrored from writes, since the flag is not at the ports
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            oie_ff <= 1'b0;
        end else if (ctl_wr) begin
            oie_ff <= reg_wdata[1];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_irq_needs_enable: assert property (overflow_irq |-> oie_ff)
        else $error("irq high with enable clear");
    a_irq_off_masked: assert property (ctl_wr && !reg_wdata[1] |=> !overflow_irq)
        else $error("irq stays after masking");
    a_oe_follows_write: assert property (pwc_wr |=> pwm_output_pin_oe == $past(reg_wdata[7:4]))
        else $error("enables differ from write");
    a_oe_holds: assert property (!pwc_wr |=> $stable(pwm_output_pin_oe))
        else $error("enables moved without write");
    a_pin_off_disabled: assert property ((pwm_output_pin_o & ~pwm_output_pin_oe) == 4'h0)
        else $error("disabled pin driven high");
    a_oe_readback: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata[7:4] == pwm_output_pin_oe)
        else $error("enable readback mismatch");
    a_force_reads_zero: assert property (reg_rd && reg_addr == 4'h0 |=> !reg_rdata[2])
        else $error("force bit reads one");
    a_reset_clears_all: assert property (disable iff (1'b0) srst |=> reg_rdata == 8'h00 && !overflow_irq
        && pwm_output_pin_oe == 4'h0)
        else $error("outputs not cleared by reset");
    c_irq: cover property (overflow_irq);
    c_pin_rise: cover property ($rose(pwm_output_pin_o[0]));
    c_ext_edge: cover property ($rose(ext_clk_in) ##1 halt_req == 1'b0);
endmodule
bind autoreload_timer_pwm autoreload_timer_pwm_props i_autoreload_timer_pwm_props (.sys_clk, .srst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_clk_in, .halt_req, .pwm_output_pin_o,
    .pwm_output_pin_oe, .overflow_irq);
`default_nettype wire

//--- pwm_load_model.sv
// Load model: resolves the four pin wires and times each pulse train
// Assumes: no pull resistor on the pins, sampled on sys_clk
`timescale 1ns/100ps
`default_nettype none
module pwm_load_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    output logic [3:0] line,
    output logic [3:0][8:0] period_ff,
    output logic [3:0][8:0] high_ff
);
    logic [3:0] last_ff;
    logic [3:0][8:0] run_ff;
    logic [3:0][8:0] hi_ff;
    // Floating wire toggles so a stale level can never pass for drive
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            line[i] = pin_oe[i] ? pin_o[i] : ~last_ff[i];
        end
    end
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            last_ff[i] <= srst ? 1'b0 : line[i];
            if (line[i] && !last_ff[i]) begin
                period_ff[i] <= run_ff[i];
                high_ff[i] <= hi_ff[i];
                run_ff[i] <= 9'h001;
                hi_ff[i] <= 9'h001;
            end else begin
                run_ff[i] <= run_ff[i] + 9'h001;
                hi_ff[i] <= hi_ff[i] + {8'h00, line[i]};
            end
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
// Testbench: registers, waveforms, prescaler, clocks and interrupt
// Assumes: design, checker and load model compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ext_clk_in = 1'b0;
    logic halt_req = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] pin_o;
    logic [3:0] pin_oe;
    logic overflow_irq;
    logic [3:0] line;
    logic [3:0][8:0] period_ff;
    logic [3:0][8:0] high_ff;
    logic [7:0] a;
    logic [7:0] b;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #20 sys_clk = ~sys_clk;
    autoreload_timer_pwm i_autoreload_timer_pwm (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ext_clk_in, .halt_req, .pwm_output_pin_o(pin_o), .pwm_output_pin_oe(pin_oe),
        .overflow_irq);
    pwm_load_model i_pwm_load_model (.sys_clk, .srst, .pin_o, .pin_oe, .line, .period_ff, .high_ff);
    // ----
    // Bus and check helpers
    // ----
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        for (int i = 0; i < 9; i++) begin
            rd(i == 8 ? 4'h9 : 4'(i), a);
            chk("reset value", 9'h000, a);
        end
        wr(4'h2, 8'h30);
        wr(4'h0, 8'h04);
        rd(4'h1, a);
        chk("forced count", 9'h030, a);
        rd(4'h0, a);
        chk("force bit", 9'h000, a);
        wr(4'h1, 8'h55);
        rd(4'h1, a);
        chk("written count", 9'h055, a);
        $display("registers done");
    endtask
    task automatic t_wave;
        wr(4'h2, 8'h00);
        wr(4'h4, 8'h80);
        wr(4'h6, 8'h40);
        wr(4'h3, 8'h54);
        wr(4'h0, 8'h08);
        tick(800);
        chk("period", 9'd256, period_ff[0]);
        chk("high time", 9'd129, high_ff[0]);
        chk("inverted high", 9'd191, high_ff[2]);
        wr(4'h2, 8'hc0);
        wr(4'h5, 8'he0);
        wr(4'h3, 8'h20);
        tick(800);
        chk("short period", 9'd64, period_ff[1]);
        chk("short high", 9'd33, high_ff[1]);
        $display("waveform done");
    endtask
    task automatic t_pol;
        wr(4'h0, 8'h00);
        a[0] = pin_o[1];
        wr(4'h3, 8'h22);
        chk("flipped pin", {8'h00, ~a[0]}, pin_o[1]);
        rd(4'h1, a);
        tick(50);
        rd(4'h1, b);
        chk("frozen count", a, b);
        $display("polarity done");
    endtask
    task automatic t_taps;
        wr(4'h2, 8'h00);
        for (int t = 0; t < 8; t++) begin
            wr(4'h1, 8'h00);
            wr(4'h0, {1'b0, 3'(t), 4'h8});
            rd(4'h1, a);
            tick(126);
            rd(4'h1, b);
            chk("counts per tap", 9'(128 >> t), b - a);
        end
        tick(1);
        halt_req <= 1'b1;
        tick(4);
        rd(4'h1, a);
        tick(126);
        rd(4'h1, b);
        chk("halted count", a, b);
        tick(1);
        halt_req <= 1'b0;
        $display("prescaler done");
    endtask
    task automatic t_ext;
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h88);
        for (int i = 0; i < 16; i++) begin
            tick(3);
            ext_clk_in <= 1'b1;
            tick(3);
            ext_clk_in <= 1'b0;
        end
        tick(4);
        rd(4'h1, a);
        chk("external edges", 9'd16, a);
        $display("external clock done");
    endtask
    task automatic t_irq;
        wr(4'h1, 8'hf0);
        wr(4'h0, 8'h0a);
        for (int i = 0; i < 40 && overflow_irq !== 1'b1; i++) @(negedge sys_clk);
        chk("irq raised", 9'h001, overflow_irq);
        wr(4'h0, 8'h02);
        rd(4'h0, a);
        chk("flag set", 9'h003, a);
        chk("irq cleared", 9'h000, overflow_irq);
        rd(4'h0, a);
        chk("flag cleared", 9'h002, a);
        wr(4'h1, 8'hf0);
        wr(4'h0, 8'h08);
        tick(40);
        wr(4'h0, 8'h00);
        chk("masked irq", 9'h000, overflow_irq);
        wr(4'h0, 8'h02);
        chk("unmasked irq", 9'h001, overflow_irq);
        // Wrap lands on the edge that samples the status read
        rd(4'h0, a);
        wr(4'h0, 8'h08);
        wr(4'h1, 8'hfe);
        rd(4'h0, a);
        rd(4'h0, b);
        chk("flag before wrap", 9'h008, a);
        chk("flag kept", 9'h009, b);
        $display("interrupt done");
    endtask
    // Ceiling well above the roughly 3100 cycles the tests need
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    initial begin
        tick(4);
        srst <= 1'b0;
        t_regs;
        t_wave;
        t_pol;
        t_taps;
        t_ext;
        t_irq;
        give_verdict;
    end
endmodule
`default_nettype wire
